// file: rtl/vbi_ctrl.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module vbi_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // bus protocol engine
  input wire vbi_pkg::vbi_lk_ev_t lk_ev,
  input wire logic [7:0] lk_rx_data,
  output vbi_pkg::vbi_lk_ctl_t lk_ctl,
  output logic [7:0] lk_tx_data,
  // interrupts
  output logic data_transfer_interrupt,
  output logic bus_control_interrupt
);

  // ==========================================================
  // apb decode
  // ==========================================================
  logic wr_en;
  logic rd_setup;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_data;
  logic hit_stat;
  logic hit_ien;
  logic hit_iclr;
  logic hit_frame;
  logic mapped;

  assign hit_ctrl = paddr == vbi_pkg::ADDR_CTRL;
  assign hit_data = paddr == vbi_pkg::ADDR_DATA;
  assign hit_stat = paddr == vbi_pkg::ADDR_STAT;
  assign hit_ien = paddr == vbi_pkg::ADDR_IEN;
  assign hit_iclr = paddr == vbi_pkg::ADDR_ICLR;
  assign hit_frame = paddr == vbi_pkg::ADDR_FRAME;
  assign mapped = hit_ctrl | hit_data | hit_stat | hit_ien | hit_iclr | hit_frame;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // state
  // ==========================================================
  vbi_pkg::vbi_ctrl_t ctrl_r;
  logic [vbi_pkg::NSTAT-1:0] stat_r;
  logic [vbi_pkg::NSTAT-1:0] ien_r;
  logic [vbi_pkg::NPEND-1:0] pend_r;
  logic [vbi_pkg::PW-1:0] pre_r;
  logic [vbi_pkg::CW-1:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic rx_full_r;
  logic tx_full_r;
  logic frame_on_r;
  logic cs_seen_r;
  logic sr_seen_r;
  logic dt_first_r;
  logic dt_req_r;
  logic nack_r;
  logic abort_r;
  logic [31:0] prdata_r;

  // ==========================================================
  // microsecond tick, stretched for slower modes
  // ==========================================================
  logic [vbi_pkg::PW-1:0] pre_lim;
  logic tick;

  assign pre_lim = vbi_pkg::PW'(vbi_pkg::US_CYC) << ctrl_r.scale;
  assign tick = pre_r == pre_lim - 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= '0;
    else
      pre_r <= (tick || lk_ev.comm_start) ? '0 : pre_r + 1'b1;
  end

  // ==========================================================
  // interval timers
  // ==========================================================
  logic [vbi_pkg::TW-1:0] t_st;
  logic [vbi_pkg::TW-1:0] t_cs;
  logic [vbi_pkg::TW-1:0] t_sr;
  logic [vbi_pkg::TW-1:0] t_dt;
  logic [vbi_pkg::NPEND-1:0] rel;

  vbi_ustimer #(.W(vbi_pkg::TW)) u_t_start (
    .pclk(pclk), .presetn(presetn), .clear(lk_ev.comm_start), .tick(tick), .count(t_st)
  );
  vbi_ustimer #(.W(vbi_pkg::TW)) u_t_csint (
    .pclk(pclk), .presetn(presetn), .clear(rel[vbi_pkg::P_CS]), .tick(tick), .count(t_cs)
  );
  vbi_ustimer #(.W(vbi_pkg::TW)) u_t_streq (
    .pclk(pclk), .presetn(presetn), .clear(rel[vbi_pkg::P_SR]), .tick(tick), .count(t_sr)
  );
  vbi_ustimer #(.W(vbi_pkg::TW)) u_t_data (
    .pclk(pclk), .presetn(presetn), .clear(rel[vbi_pkg::P_DT]), .tick(tick), .count(t_dt)
  );

  // ==========================================================
  // release gates
  // ==========================================================
  logic slave_tx;
  logic g_te;
  logic g_cs;
  logic g_sr;
  logic g_ec;
  logic g_dt;
  logic [vbi_pkg::TW-1:0] t1_min;
  logic [vbi_pkg::TW-1:0] t2_min;

  assign slave_tx = ~ctrl_r.master & ctrl_r.tx_mode;
  assign t1_min = ctrl_r.master ? vbi_pkg::TW'(vbi_pkg::T1_MST_US)
                                : vbi_pkg::TW'(vbi_pkg::T1_SLV_US);
  assign t2_min = ctrl_r.master ? vbi_pkg::TW'(vbi_pkg::T2_MST_US)
                                : vbi_pkg::TW'(vbi_pkg::T2_SLV_US);
  assign g_te = sr_seen_r ? t_sr >= vbi_pkg::TW'(vbi_pkg::T6_US)
              : cs_seen_r ? t_cs >= vbi_pkg::TW'(vbi_pkg::T3_US)
              : t_st >= t1_min;
  assign g_cs = t_st >= t2_min;
  assign g_sr = cs_seen_r & (t_cs >= vbi_pkg::TW'(vbi_pkg::T4_STX_US));
  assign g_ec = cs_seen_r & (slave_tx ? sr_seen_r & (t_sr >= vbi_pkg::TW'(vbi_pkg::T7_US))
                                      : t_cs >= vbi_pkg::TW'(vbi_pkg::T4_US));
  assign g_dt = dt_first_r | (t_dt >= vbi_pkg::TW'(vbi_pkg::T5_US));

  // early events wait in pend_r until their minimum interval has passed
  assign rel = pend_r & {g_dt, g_te, g_ec, g_sr, g_cs} & {vbi_pkg::NPEND{frame_on_r}};

  // ==========================================================
  // data path
  // ==========================================================
  logic rx_acc;
  logic rx_rej;
  logic tx_ok;
  logic underrun;
  logic byte_inc;
  logic frame_end;
  logic err;
  logic kill;
  logic start;
  logic data_rd;
  logic data_wr;
  logic [vbi_pkg::NPEND-1:0] pset;

  assign start = lk_ev.comm_start & ctrl_r.enable;
  assign rx_acc = frame_on_r & lk_ev.rx_valid & ~rx_full_r;
  assign rx_rej = frame_on_r & lk_ev.rx_valid & rx_full_r;
  assign tx_ok = frame_on_r & lk_ev.tx_take & tx_full_r;
  assign underrun = frame_on_r & slave_tx & lk_ev.tx_take & ~tx_full_r;
  assign byte_inc = rx_acc | tx_ok;
  assign frame_end = byte_inc & (cnt_r == vbi_pkg::CW'(vbi_pkg::FRAME_BYTES - 1));
  assign err = rel[vbi_pkg::P_TE] | underrun
             | (frame_on_r & (lk_ev.err_parity | lk_ev.err_ack));
  assign kill = err | start | ~ctrl_r.enable;
  assign data_rd = rd_acc & hit_data;
  assign data_wr = wr_en & hit_data;
  // a rejected byte raises only the overrun status and a nack, no data request; its repeat is taken as a fresh arrival
  assign pset = {rx_acc | tx_ok, lk_ev.err_timing, lk_ev.end_comm,
                 lk_ev.status_req & slave_tx, lk_ev.cs_point} & {vbi_pkg::NPEND{frame_on_r}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= '0;
    else
      pend_r <= kill ? '0 : (pend_r | pset) & ~rel;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_on_r <= 1'b0;
    else if (start)
      frame_on_r <= 1'b1;
    else if (err || rel[vbi_pkg::P_EC] || !ctrl_r.enable)
      frame_on_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_seen_r <= 1'b0;
      sr_seen_r <= 1'b0;
      dt_first_r <= 1'b0;
    end
    else
    begin
      cs_seen_r <= ~start & (cs_seen_r | rel[vbi_pkg::P_CS]);
      sr_seen_r <= ~start & (sr_seen_r | rel[vbi_pkg::P_SR]);
      dt_first_r <= start | (dt_first_r & ~rel[vbi_pkg::P_DT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (start || frame_end)
      cnt_r <= '0;
    else if (byte_inc)
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_r <= 8'h00;
      rx_full_r <= 1'b0;
    end
    else
    begin
      if (rx_acc)
        rx_r <= lk_rx_data;
      rx_full_r <= rx_acc | (rx_full_r & ~data_rd & ~start);
    end
  end

  // a cpu write in the cycle the engine takes the byte still counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_r <= 8'h00;
      tx_full_r <= 1'b0;
    end
    else
    begin
      if (data_wr)
        tx_r <= pwdata[7:0];
      tx_full_r <= data_wr | (tx_full_r & ~tx_ok);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nack_r <= 1'b0;
      abort_r <= 1'b0;
      dt_req_r <= 1'b0;
    end
    else
    begin
      nack_r <= rx_rej;
      abort_r <= err;
      dt_req_r <= rel[vbi_pkg::P_DT] | (dt_req_r & ~data_rd & ~data_wr & ~kill);
    end
  end

  // ==========================================================
  // interrupt status, enable, clear
  // ==========================================================
  logic [vbi_pkg::NSTAT-1:0] sset;
  logic [vbi_pkg::NSTAT-1:0] sclr;

  assign sset[vbi_pkg::S_CS] = rel[vbi_pkg::P_CS];
  assign sset[vbi_pkg::S_SR] = rel[vbi_pkg::P_SR];
  assign sset[vbi_pkg::S_EC] = rel[vbi_pkg::P_EC];
  assign sset[vbi_pkg::S_EF] = frame_end;
  assign sset[vbi_pkg::S_TE] = rel[vbi_pkg::P_TE];
  assign sset[vbi_pkg::S_PE] = frame_on_r & lk_ev.err_parity;
  assign sset[vbi_pkg::S_AE] = frame_on_r & lk_ev.err_ack;
  assign sset[vbi_pkg::S_UR] = underrun;
  assign sset[vbi_pkg::S_OR] = rx_rej;
  assign sset[vbi_pkg::S_DT] = rel[vbi_pkg::P_DT];
  assign sclr = (wr_en & hit_iclr) ? pwdata[vbi_pkg::NSTAT-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_r <= '0;
      ien_r <= '0;
      ctrl_r <= vbi_pkg::CTRL_RST;
    end
    else
    begin
      stat_r <= (stat_r & ~sclr) | sset;
      if (wr_en && hit_ien)
        ien_r <= pwdata[vbi_pkg::NSTAT-1:0];
      if (wr_en && hit_ctrl)
        ctrl_r <= pwdata[vbi_pkg::CTRL_W-1:0];
    end
  end

  assign bus_control_interrupt = |(stat_r & ien_r);
  assign data_transfer_interrupt = dt_req_r;

  // ==========================================================
  // read data, captured in the setup cycle
  // ==========================================================
  logic [31:0] rd_word;

  assign rd_word = hit_ctrl ? 32'(ctrl_r)
                 : hit_data ? {24'h000000, rx_r}
                 : hit_stat ? 32'(stat_r)
                 : hit_ien ? 32'(ien_r)
                 : hit_frame ? {23'h000000, frame_on_r, tx_full_r, rx_full_r, cnt_r}
                 : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (rd_setup)
      prdata_r <= rd_word;
  end

  assign prdata = prdata_r;
  assign lk_ctl = '{nack: nack_r, abort: abort_r, tx_valid: tx_full_r};
  assign lk_tx_data = tx_r;

endmodule // vbi_ctrl

// file: rtl/vbi_pkg.sv
package vbi_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_HZ = 125_000_000;
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam int TW = 12;
  localparam int PW = 11;
  // minimum interrupt intervals, microseconds at the base bit rate
  localparam int T1_MST_US = 93;
  localparam int T1_SLV_US = 96;
  localparam int T2_MST_US = 1282;
  localparam int T2_SLV_US = 1192;
  localparam int T3_US = 15;
  localparam int T4_US = 1012;
  localparam int T5_US = 375;
  localparam int T4_STX_US = 225;
  localparam int T6_US = 15;
  localparam int T7_US = 787;
  localparam int FRAME_BYTES = 32;
  localparam int CW = 6;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IEN = 8'h0c;
  localparam logic [7:0] ADDR_ICLR = 8'h10;
  localparam logic [7:0] ADDR_FRAME = 8'h14;

  // status bit positions
  localparam int NSTAT = 10;
  localparam int S_CS = 0;
  localparam int S_SR = 1;
  localparam int S_EC = 2;
  localparam int S_EF = 3;
  localparam int S_TE = 4;
  localparam int S_PE = 5;
  localparam int S_AE = 6;
  localparam int S_UR = 7;
  localparam int S_OR = 8;
  localparam int S_DT = 9;

  // deferred event slots
  localparam int NPEND = 5;
  localparam int P_CS = 0;
  localparam int P_SR = 1;
  localparam int P_EC = 2;
  localparam int P_TE = 3;
  localparam int P_DT = 4;

  typedef struct packed {
    logic [1:0] scale;
    logic tx_mode;
    logic master;
    logic enable;
  } vbi_ctrl_t;

  localparam int CTRL_W = 5;
  localparam vbi_ctrl_t CTRL_RST = 5'h00;

  // events from the bus protocol engine, one-cycle pulses
  typedef struct packed {
    logic comm_start;
    logic cs_point;
    logic status_req;
    logic end_comm;
    logic err_timing;
    logic err_parity;
    logic err_ack;
    logic rx_valid;
    logic tx_take;
  } vbi_lk_ev_t;

  // answers to the bus protocol engine
  typedef struct packed {
    logic nack;
    logic abort;
    logic tx_valid;
  } vbi_lk_ctl_t;

endpackage

// file: rtl/vbi_ustimer.sv
`timescale 1ns/1ps
module vbi_ustimer #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic tick,
  // elapsed microseconds, saturating
  output logic [W-1:0] count
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // saturate so a long idle never wraps into a false short interval
  assign count_nxt = clear ? '0 : (tick && count_r != '1) ? count_r + 1'b1 : count_r;
  assign count = count_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

endmodule // vbi_ustimer

// file: test/vbi_lk_model.sv
`timescale 1ns/1ps
module vbi_lk_model (
  // clock
  input wire logic pclk,
  // events towards the controller
  output vbi_pkg::vbi_lk_ev_t lk_ev,
  output logic [7:0] lk_rx_data,
  // answers from the controller
  input wire vbi_pkg::vbi_lk_ctl_t lk_ctl,
  input wire logic [7:0] lk_tx_data
);
  int n_nack = 0;
  int n_abort = 0;
  logic [7:0] last_tx = 8'h00;

  initial
  begin
    lk_ev = '0;
    lk_rx_data = 8'h00;
  end

  always @(posedge pclk)
  begin
    if (lk_ctl.nack)
      n_nack <= n_nack + 1;
    if (lk_ctl.abort)
      n_abort <= n_abort + 1;
  end

  // ==========
  // one event pulse; a released data line shows the inverse
  task automatic send(input int k, input logic [7:0] d);
    @(posedge pclk);
    lk_ev <= vbi_pkg::vbi_lk_ev_t'(9'h001 << k);
    lk_rx_data <= d;
    if (k == 0)
      last_tx <= lk_tx_data;
    @(posedge pclk);
    lk_ev <= '0;
    lk_rx_data <= ~d;
  endtask
endmodule // vbi_lk_model

// file: test/vbi_ctrl_assertions.sv
`timescale 1ns/1ps
module vbi_ctrl_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // link
  input wire vbi_pkg::vbi_lk_ev_t lk_ev,
  input wire vbi_pkg::vbi_lk_ctl_t lk_ctl,
  // interrupts
  input wire logic data_transfer_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one tick of slack for the microsecond timer
  localparam int GAP = 374 * 125;
  logic acc;
  logic mapped;
  logic wr_data;
  logic dt_q_r;
  logic [16:0] gap_r;
  assign acc = psel && penable;
  assign mapped = paddr <= 8'h14 && paddr[1:0] == 2'b00;
  assign wr_data = acc && pwrite && paddr == vbi_pkg::ADDR_DATA;

  // ==========
  // cycles since the last data interrupt; a new frame frees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dt_q_r <= 1'b0;
      gap_r <= '1;
    end
    else
    begin
      dt_q_r <= data_transfer_interrupt;
      if (lk_ev.comm_start)
        gap_r <= '1;
      else if (data_transfer_interrupt && !dt_q_r)
        gap_r <= '0;
      else if (gap_r != '1)
        gap_r <= gap_r + 17'h1;
    end
  end

  // ==========
  apb_ready_a: assert property (acc |-> pready) else $error("access without ready");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no refusal");
  unmapped_zero_a: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("mapped refused");
  nack_cause_a: assert property (lk_ctl.nack |-> $past(lk_ev.rx_valid))
    else $error("nack without byte");
  tx_load_a: assert property ($rose(lk_ctl.tx_valid) |-> $past(wr_data))
    else $error("tx byte without write");
  tx_take_a: assert property (lk_ctl.tx_valid && lk_ev.tx_take && !wr_data |=> !lk_ctl.tx_valid)
    else $error("tx byte not released");
  dt_gap_a: assert property (data_transfer_interrupt && !dt_q_r |-> gap_r >= GAP)
    else $error("data interrupts too close");
  abort_quiet_a: assert property (lk_ctl.abort && !$past(lk_ev.tx_take) |=>
    !data_transfer_interrupt [*3]) else $error("interrupt after error");
endmodule // vbi_ctrl_assertions

bind vbi_ctrl vbi_ctrl_assertions chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .lk_ev(lk_ev), .lk_ctl(lk_ctl),
  .data_transfer_interrupt(data_transfer_interrupt));

// file: test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  vbi_pkg::vbi_lk_ev_t lk_ev;
  vbi_pkg::vbi_lk_ctl_t lk_ctl;
  logic [7:0] lk_rx_data;
  logic [7:0] lk_tx_data;
  logic dti;
  logic bci;
  logic [31:0] q;
  logic err;
  int fails = 0;
  int n_tests = 0;

  always #4 pclk = ~pclk;

  vbi_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lk_ev(lk_ev), .lk_rx_data(lk_rx_data), .lk_ctl(lk_ctl),
    .lk_tx_data(lk_tx_data), .data_transfer_interrupt(dti), .bus_control_interrupt(bci));

  vbi_lk_model lkm (.pclk(pclk), .lk_ev(lk_ev), .lk_rx_data(lk_rx_data), .lk_ctl(lk_ctl),
    .lk_tx_data(lk_tx_data));

  // ==========
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // settle past the edge before sampling
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  task automatic stop_test;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #800000;
    fails++;
    stop_test();
  end

  // ==========
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    apb(vbi_pkg::ADDR_FRAME, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    apb(vbi_pkg::ADDR_ICLR, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    apb(8'h18, 1'b0, 32'h0);
    `CHK({err, q}, 33'h100000000)
    apb(vbi_pkg::ADDR_IEN, 1'b1, 32'h3ff);
    // slave reception, second byte arrives unread
    apb(vbi_pkg::ADDR_CTRL, 1'b1, 32'h1);
    lkm.send(8, 8'h00);
    lkm.send(1, 8'ha5);
    idle(4);
    `CHK(dti, 1'b1)
    lkm.send(1, 8'h3c);
    idle(2);
    `CHK(lkm.n_nack, 1)
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[9:8], 2'b11)
    apb(vbi_pkg::ADDR_DATA, 1'b0, 32'h0);
    `CHK(q[7:0], 8'ha5)
    `CHK(dti, 1'b0)
    // the repeat arrives early and waits out the data interval
    lkm.send(1, 8'h3c);
    idle(46000);
    `CHK(dti, 1'b0)
    idle(1300);
    `CHK(dti, 1'b1)
    apb(vbi_pkg::ADDR_DATA, 1'b0, 32'h0);
    `CHK(q[7:0], 8'h3c)
    // parity error silences the frame
    lkm.send(3, 8'h00);
    idle(3);
    `CHK(lkm.n_abort, 1)
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[5], 1'b1)
    lkm.send(1, 8'h77);
    idle(4);
    `CHK(dti, 1'b0)
    apb(vbi_pkg::ADDR_FRAME, 1'b0, 32'h0);
    `CHK(q[8], 1'b0)
    apb(vbi_pkg::ADDR_IEN, 1'b1, 32'h0);
    `CHK(bci, 1'b0)
    apb(vbi_pkg::ADDR_IEN, 1'b1, 32'h3ff);
    `CHK(bci, 1'b1)
    apb(vbi_pkg::ADDR_ICLR, 1'b1, 32'h3ff);
    `CHK(bci, 1'b0)
    // early timing error held to its minimum interval
    apb(vbi_pkg::ADDR_CTRL, 1'b1, 32'h3);
    lkm.send(8, 8'h00);
    lkm.send(7, 8'h00);
    lkm.send(4, 8'h00);
    idle(11490);
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[4], 1'b0)
    idle(400);
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[4], 1'b1)
    `CHK(q[0], 1'b0)
    `CHK(lkm.n_abort, 2)
    // doubled tick: the same gate opens twice as late
    apb(vbi_pkg::ADDR_ICLR, 1'b1, 32'h3ff);
    apb(vbi_pkg::ADDR_CTRL, 1'b1, 32'hb);
    lkm.send(8, 8'h00);
    lkm.send(4, 8'h00);
    idle(23000);
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[4], 1'b0)
    idle(400);
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[4], 1'b1)
    // master transmission of a full frame
    apb(vbi_pkg::ADDR_ICLR, 1'b1, 32'h3ff);
    apb(vbi_pkg::ADDR_CTRL, 1'b1, 32'h7);
    lkm.send(8, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      apb(vbi_pkg::ADDR_DATA, 1'b1, i);
      `CHK(lk_ctl.tx_valid, 1'b1)
      lkm.send(0, 8'h00);
      idle(2);
      apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
      `CHK(q[3], i == 31)
    end
    `CHK(lkm.last_tx, 8'h1f)
    apb(vbi_pkg::ADDR_FRAME, 1'b0, 32'h0);
    `CHK(q[8:0], 9'h100)
    // slave transmission without a byte ready
    apb(vbi_pkg::ADDR_CTRL, 1'b1, 32'h5);
    lkm.send(8, 8'h00);
    lkm.send(0, 8'h00);
    idle(2);
    `CHK(lkm.n_abort, 4)
    apb(vbi_pkg::ADDR_STAT, 1'b0, 32'h0);
    `CHK(q[7], 1'b1)
    stop_test();
  end
endmodule // testbench
